// ===== hw/bstc_pkg.sv
package bstc_pkg;
    // window offsets (byte addresses inside the 16-byte i/o window)
    localparam logic [3:0] TCR_OFS = 4'h0;
    localparam logic [3:0] BANK_SEL_OFS = 4'he;
    localparam int NUM_BANKS = 5;
    localparam logic [2:0] BANK_TX_CTRL = 3'h0;
    localparam logic [2:0] BANK_LAST = 3'h4;
    localparam logic [7:0] BSEL_SIGNATURE = 8'h33;
    localparam logic [7:0] EMPTY_BYTE = 8'h33;
    // transmit control field positions
    localparam int TC_TX_ENABLE = 0;
    localparam int TC_LOOP = 1;
    localparam int TC_FORCE_COLLISION = 2;
    localparam int TC_RSV_PAD = 3;
    localparam int TC_PAD_EN = 7;
    localparam int TC_OMIT_FCS = 8;
    localparam int TC_MONCS = 10;
    localparam int TC_FDX = 11;
    localparam int TC_SQE = 12;
    localparam int TC_PHYLOOP = 13;
    localparam int TC_RSV14 = 14;
    localparam int TC_SWITCHED_FULL_DUPLEX = 15;
    // writable bits of the transmit control word
    localparam logic [15:0] TC_WR_MASK = 16'hbd87;
    localparam logic [15:0] TC_RESET = 16'h0000;
    localparam logic [2:0] BANK_RESET = 3'h0;

    // loopback routing point
    typedef enum logic [1:0] {
        BSTC_RT_NETWORK,
        BSTC_RT_ENDEC,
        BSTC_RT_PHY
    } bstc_route_t;

    // host access on the i/o window
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } bstc_hreq_t;

    // settings delivered to the transmit engine
    typedef struct packed {
        logic tx_en;
        logic append_fcs;
        logic pad_short;
        logic full_duplex;
        logic monitor_carrier;
        logic defer_collide;
        logic force_collision;
        logic accept_own;
        logic halt_sqe;
        logic drive_network;
        bstc_route_t route;
    } bstc_txcfg_t;

    // events reported back by the transmit engine
    typedef struct packed {
        logic frame_busy;
        logic collision;
        logic sqe_fail;
        logic carrier_fail;
        logic fatal_error;
    } bstc_txev_t;
endpackage

// ===== hw/bstc_byte_reg.sv
module bstc_byte_reg
    import bstc_pkg::*;
#(
    parameter int W = 16,
    parameter logic [15:0] RST_VAL = 16'h0000,
    parameter logic [15:0] WMASK = 16'hffff
)(
    input wire logic mclk, // clock
    input wire logic rst, // sync reset
    input wire logic we, // write strobe
    input wire logic [1:0] be, // byte lanes
    input wire logic [W-1:0] wdata, // write data
    input wire logic [W-1:0] hw_clr, // hardware clear per bit
    output logic [W-1:0] q // stored word
);
    logic [W-1:0] lane_mask;

    // byte lanes widened to bit mask
    always_comb
    begin
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    end

    // byte-lane write with hardware clear; writes take precedence
    always_ff @(posedge mclk)
    begin
        if (rst)
            q <= RST_VAL;
        else
            q <= ((q & ~hw_clr) & ~(lane_mask & WMASK & {W{we}}))
                | (wdata & lane_mask & WMASK & {W{we}});
    end
endmodule

// ===== hw/bstc_top.sv
module bstc_top
    import bstc_pkg::*;
(
    input wire logic mclk, // 125 mhz clock
    input wire logic rst, // sync reset, active high
    input wire logic power_down, // function in power down
    input wire logic wide_bus, // 16-bit bus mode
    input wire bstc_hreq_t hreq, // host access
    input wire logic [15:0] other_rdata, // data from other bank regs
    input wire bstc_txev_t tx_ev, // transmit engine events
    output logic [15:0] rdata, // read data, registered
    output logic rvalid, // read data valid pulse
    output logic [2:0] bank_reg, // active bank code
    output logic bank_valid, // active bank exists
    output logic other_sel, // access goes to other bank regs
    output bstc_txcfg_t txcfg // transmit settings
);
    logic [15:0] tc_q;
    logic [15:0] tc_clr;
    logic tc_we;
    logic bsel_hit;
    logic bsel_we;
    logic [1:0] be_eff;
    logic [15:0] rdata_next;
    logic stop_pending_reg;
    bstc_txcfg_t txcfg_next;

    // code within 0..4 names an existing bank
    function automatic logic bank_exists(input logic [2:0] code);
        bank_exists = (code <= BANK_LAST);
    endfunction

    // byte enables honour 8-bit mode: only one lane at a time
    function automatic logic [1:0] lanes(input logic wide,
                                         input logic [1:0] be,
                                         input logic a0);
        if (wide)
            lanes = be;
        else
            lanes = a0 ? 2'b10 : 2'b01;
    endfunction

    // word select: offset picks even byte, offset plus one odd byte
    always_comb
    begin
        be_eff = lanes(wide_bus, hreq.be, hreq.addr[0]);
        bsel_hit = (hreq.addr[3:1] == BANK_SEL_OFS[3:1])
            && !power_down;
        bsel_we = hreq.wr && bsel_hit && be_eff[0];
        tc_we = hreq.wr && !power_down && !bsel_hit
            && bank_reg == BANK_TX_CTRL
            && hreq.addr[3:1] == TCR_OFS[3:1];
    end

    // routes other offsets of existing banks to the surrounding registers
    always_ff @(posedge mclk)
    begin
        if (rst)
            other_sel <= 1'b0;
        else
            other_sel <= (hreq.rd || hreq.wr) && !power_down && !bsel_hit
                && bank_exists(bank_reg)
                && !(bank_reg == BANK_TX_CTRL
                     && hreq.addr[3:1] == TCR_OFS[3:1]);
    end

    // bank selector; only the low byte holds the code
    always_ff @(posedge mclk)
    begin
        if (rst)
            bank_reg <= BANK_RESET;
        else if (bsel_we)
            bank_reg <= hreq.wdata[2:0];
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            bank_valid <= 1'b1;
        else if (bsel_we)
            bank_valid <= bank_exists(hreq.wdata[2:0]);
    end

    // hardware clears: force collision after collision, enable on error
    always_comb
    begin
        tc_clr = 16'h0000;
        tc_clr[TC_FORCE_COLLISION] = tx_ev.collision;
        tc_clr[TC_TX_ENABLE] = tx_ev.fatal_error
            || (tx_ev.sqe_fail && tc_q[TC_SQE])
            || (tx_ev.carrier_fail && tc_q[TC_MONCS] && !tc_q[TC_SWITCHED_FULL_DUPLEX]);
    end

    // transmit control word, reserved bits never stored
    bstc_byte_reg #(
        .W(16),
        .RST_VAL(TC_RESET),
        .WMASK(TC_WR_MASK)
    ) u_tx_control (
        .mclk(mclk),
        .rst(rst),
        .we(tc_we),
        .be(be_eff),
        .wdata(hreq.wdata),
        .hw_clr(tc_clr),
        .q(tc_q)
    );

    // enable seen during a frame; keeps a cleared enable until frame ends,
    // so the settings never dip low for a cycle; an error ends it at once
    always_ff @(posedge mclk)
    begin
        if (rst)
            stop_pending_reg <= 1'b0;
        else if (tc_clr[TC_TX_ENABLE])
            stop_pending_reg <= 1'b0;
        else if (tc_q[TC_TX_ENABLE] && tx_ev.frame_busy)
            stop_pending_reg <= 1'b1;
        else if (!tx_ev.frame_busy)
            stop_pending_reg <= 1'b0;
    end

    // derived transmit settings
    always_comb
    begin
        txcfg_next = '0;
        txcfg_next.tx_en = tc_q[TC_TX_ENABLE]
            || (stop_pending_reg && tx_ev.frame_busy
                && !tc_clr[TC_TX_ENABLE]);
        txcfg_next.append_fcs = !tc_q[TC_OMIT_FCS];
        txcfg_next.pad_short = tc_q[TC_PAD_EN];
        txcfg_next.full_duplex = tc_q[TC_FDX] || tc_q[TC_SWITCHED_FULL_DUPLEX];
        txcfg_next.monitor_carrier = tc_q[TC_MONCS]
            && !tc_q[TC_SWITCHED_FULL_DUPLEX]
            && !tc_q[TC_PHYLOOP] && !tc_q[TC_LOOP];
        txcfg_next.defer_collide = !tc_q[TC_SWITCHED_FULL_DUPLEX]
            && !tc_q[TC_LOOP] && !tc_q[TC_PHYLOOP];
        txcfg_next.force_collision = tc_q[TC_FORCE_COLLISION];
        txcfg_next.accept_own = tc_q[TC_FDX] || tc_q[TC_SWITCHED_FULL_DUPLEX];
        txcfg_next.halt_sqe = tc_q[TC_SQE] && !tc_q[TC_SWITCHED_FULL_DUPLEX];
        if (tc_q[TC_PHYLOOP])
            txcfg_next.route = BSTC_RT_PHY;
        else if (tc_q[TC_LOOP])
            txcfg_next.route = BSTC_RT_ENDEC;
        else
            txcfg_next.route = BSTC_RT_NETWORK;
        txcfg_next.drive_network =
            (txcfg_next.route == BSTC_RT_NETWORK);
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            txcfg <= '0;
        else
            txcfg <= txcfg_next;
    end

    // read mux: selector, transmit control, empty bank or others
    always_comb
    begin
        rdata_next = 16'h0000;
        if (bsel_hit)
            rdata_next = {BSEL_SIGNATURE, 5'h00, bank_reg};
        else if (!bank_exists(bank_reg))
            rdata_next = {EMPTY_BYTE, EMPTY_BYTE};
        else if (bank_reg == BANK_TX_CTRL && hreq.addr[3:1] == TCR_OFS[3:1])
            rdata_next = tc_q;
        else
            rdata_next = other_rdata;
        // odd byte in 8-bit mode moves to the low lane
        if (!wide_bus && hreq.addr[0])
            rdata_next = {8'h00, rdata_next[15:8]};
        if (power_down)
            rdata_next = 16'h0000;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            rdata <= 16'h0000;
        else if (hreq.rd)
            rdata <= rdata_next;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            rvalid <= 1'b0;
        else
            rvalid <= hreq.rd && !power_down;
    end
endmodule

// ===== bench/bstc_tx_engine_model.sv
module bstc_tx_engine_model
    import bstc_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic [2:0] ev_cmd, // event to report
    input wire logic busy, // frame in flight
    output bstc_txev_t tx_ev, // events to the block
    output logic [15:0] other_rdata // other bank data
);
    timeunit 1ns;
    timeprecision 100ps;
    // one-cycle event pulses, one edge after the command
    always_ff @(posedge mclk)
    begin
        tx_ev.frame_busy <= busy;
        tx_ev.collision <= ev_cmd == 3'h1;
        tx_ev.sqe_fail <= ev_cmd == 3'h2;
        tx_ev.carrier_fail <= ev_cmd == 3'h3;
        tx_ev.fatal_error <= ev_cmd == 3'h4;
    end
    // other bank registers answer with a fixed word
    assign other_rdata = 16'hc35a;
endmodule

// ===== bench/bstc_top_assertions.sv
module bstc_checker
    import bstc_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic rst, // reset
    input wire logic power_down, // power down
    input wire logic wide_bus, // 16-bit mode
    input wire bstc_hreq_t hreq, // host access
    input wire logic [15:0] other_rdata, // other data
    input wire bstc_txev_t tx_ev, // engine events
    input wire logic [15:0] rdata, // read data
    input wire logic rvalid, // read valid
    input wire logic [2:0] bank_reg, // bank code
    input wire logic bank_valid, // bank exists
    input wire logic other_sel, // other access
    input wire bstc_txcfg_t txcfg // settings
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    logic acc;
    logic tc_wr;
    // a word access that the block takes
    assign acc = !power_down && wide_bus;
    // a word write to the transmit control register
    assign tc_wr = hreq.wr && acc && hreq.addr == TCR_OFS
        && bank_reg == BANK_TX_CTRL && hreq.be == 2'h3;
    chk_sig_read: assert property (hreq.rd && acc
        && hreq.addr == BANK_SEL_OFS
        |=> rvalid && rdata[15:8] == BSEL_SIGNATURE) else $error("bad sig");
    chk_bank_write: assert property (hreq.wr && acc && hreq.be[0]
        && hreq.addr == BANK_SEL_OFS |=> bank_reg == $past(hreq.wdata[2:0]))
        else $error("bank not taken");
    chk_bank_exists: assert property (bank_valid == (bank_reg <= BANK_LAST))
        else $error("bank valid wrong");
    chk_empty_read: assert property (hreq.rd && acc && !bank_valid
        && hreq.addr < BANK_SEL_OFS |=> rdata == 16'h3333) else $error("empty");
    chk_pd_ignore: assert property (power_down |=> !rvalid)
        else $error("read in power down");
    chk_fcs_follow: assert property (tc_wr |-> ##2
        txcfg.append_fcs == !$past(hreq.wdata[TC_OMIT_FCS], 2)) else $error("fcs");
    chk_pad_follow: assert property (tc_wr |-> ##2
        txcfg.pad_short == $past(hreq.wdata[TC_PAD_EN], 2)) else $error("pad");
    chk_switched_full_duplex_force: assert property (tc_wr && hreq.wdata[TC_SWITCHED_FULL_DUPLEX]
        |-> ##2 txcfg.full_duplex && !txcfg.monitor_carrier)
        else $error("switched_full_duplex");
    chk_loop_quiet: assert property (tc_wr
        && (hreq.wdata[TC_LOOP] || hreq.wdata[TC_PHYLOOP])
        |-> ##2 !txcfg.drive_network && txcfg.route != BSTC_RT_NETWORK)
        else $error("loop drives net");
    chk_other_route: assert property (hreq.rd && acc && bank_valid
        && bank_reg != BANK_TX_CTRL && hreq.addr < BANK_SEL_OFS
        |=> other_sel) else $error("other access not routed");
    chk_force_collision_clear: assert property (txcfg.force_collision
        && tx_ev.collision |-> ##2 !txcfg.force_collision) else $error("force_collision");
    cover property (hreq.rd && !bank_valid);
    cover property (txcfg.force_collision && tx_ev.collision);
    cover property (txcfg.route == BSTC_RT_PHY);
endmodule
bind bstc_top bstc_checker i_chk (
    .mclk(mclk),
    .rst(rst),
    .power_down(power_down),
    .wide_bus(wide_bus),
    .hreq(hreq),
    .other_rdata(other_rdata),
    .tx_ev(tx_ev),
    .rdata(rdata),
    .rvalid(rvalid),
    .bank_reg(bank_reg),
    .bank_valid(bank_valid),
    .other_sel(other_sel),
    .txcfg(txcfg)
);

// ===== bench/test_bstc_top.sv
module test_bstc_top import bstc_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 0, rst = 1, power_down = 0, wide_bus = 1, busy = 0;
    logic [2:0] ev_cmd = 3'h0, bank_reg;
    bstc_hreq_t hreq = '0;
    logic [15:0] other_rdata, rdata;
    logic rvalid, bank_valid, other_sel;
    bstc_txev_t tx_ev;
    bstc_txcfg_t txcfg;
    int mismatches = 0, n_tests = 0, cyc = 0;
    bstc_top i_dut (
        .mclk(mclk),
        .rst(rst),
        .power_down(power_down),
        .wide_bus(wide_bus),
        .hreq(hreq),
        .other_rdata(other_rdata),
        .tx_ev(tx_ev),
        .rdata(rdata),
        .rvalid(rvalid),
        .bank_reg(bank_reg),
        .bank_valid(bank_valid),
        .other_sel(other_sel),
        .txcfg(txcfg)
    );
    bstc_tx_engine_model i_eng (
        .mclk(mclk),
        .ev_cmd(ev_cmd),
        .busy(busy),
        .tx_ev(tx_ev),
        .other_rdata(other_rdata)
    );
    // 125 mhz clock
    always #4 mclk = ~mclk;
    // cut a hang short
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            mismatches++;
            test_done();
        end
    end
    task automatic test_done();
        $display("compares %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [1:0] b,
                      input logic [15:0] d);
        @(posedge mclk) #1;
        hreq = {1'b0, 1'b1, a, b, d};
        @(posedge mclk) #1;
        hreq.wr = 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e,
                      input logic [15:0] m = 16'hffff, input logic v = 1);
        @(posedge mclk) #1;
        hreq = {1'b1, 1'b0, a, 2'h3, 16'h0};
        @(posedge mclk) #1;
        hreq.rd = 1'b0;
        cmp(rvalid, v);
        if (v)
            cmp(rdata & m, e);
    endtask
    task automatic txw(input logic [15:0] d);
        wr(TCR_OFS, 2'h3, d);
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic ev(input logic [2:0] c);
        @(posedge mclk) #1;
        ev_cmd = c;
        @(posedge mclk) #1;
        ev_cmd = 3'h0;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    // main sequence of tests
    initial
    begin
        repeat (6) @(posedge mclk);
        #1 rst = 0;
        rd(4'he, 16'h3300);
        rd(4'h0, 16'h0000);
        cmp(txcfg.append_fcs, 1);
        $display("test reset done");
        for (int c = 0; c < 8; c++)
        begin
            wr(4'he, 2'h1, {13'h0, 3'(c)});
            rd(4'he, {8'h33, 5'h0, 3'(c)});
            wr(4'h0, 2'h3, c > 4 ? 16'h0 : 16'hffff);
            rd(4'h0, c > 4 ? 16'h3333 : c == 0 ? 16'hbd87 : 16'hc35a);
        end
        wr(4'he, 2'h1, 16'h0);
        rd(4'h0, 16'hbd87);
        wr(4'h0, 2'h1, 16'h0);
        rd(4'h0, 16'hbd00);
        wr(4'h0, 2'h2, 16'h0100);
        rd(4'h0, 16'h0100);
        wide_bus = 0;
        rd(4'h1, 16'h0001, 16'h00ff);
        wide_bus = 1;
        $display("test banks done");
        txw(16'h0100);
        cmp(txcfg.append_fcs, 0);
        cmp(txcfg.accept_own, 0);
        txw(16'h8080);
        cmp(txcfg.pad_short, 1);
        cmp(txcfg.full_duplex, 1);
        cmp(txcfg.defer_collide, 0);
        txw(16'h0c00);
        cmp(txcfg.accept_own, 1);
        cmp(txcfg.monitor_carrier, 1);
        cmp(txcfg.defer_collide, 1);
        txw(16'h2002);
        cmp(txcfg.route, BSTC_RT_PHY);
        cmp(txcfg.drive_network, 0);
        txw(16'h0002);
        cmp(txcfg.route, BSTC_RT_ENDEC);
        txw(16'h0000);
        cmp(txcfg.drive_network, 1);
        wr(4'h4, 2'h3, 16'h8000);
        wr(4'h4, 2'h3, 16'h0000);
        rd(4'h4, 16'hc35a);
        rd(4'h0, 16'h0000);
        $display("test settings done");
        txw(16'h0005);
        ev(3'h1);
        cmp(txcfg.force_collision, 0);
        txw(16'h1001);
        cmp(txcfg.halt_sqe, 1);
        ev(3'h2);
        cmp(txcfg.tx_en, 0);
        txw(16'h0001);
        ev(3'h2);
        cmp(txcfg.tx_en, 1);
        txw(16'h0401);
        ev(3'h3);
        cmp(txcfg.tx_en, 0);
        txw(16'h0001);
        busy = 1;
        txw(16'h0000);
        cmp(txcfg.tx_en, 1);
        busy = 0;
        ev(3'h0);
        cmp(txcfg.tx_en, 0);
        txw(16'h0001);
        ev(3'h4);
        cmp(txcfg.tx_en, 0);
        $display("test events done");
        power_down = 1;
        wr(4'he, 2'h1, 16'h0003);
        rd(4'he, 16'h0, 16'h0, 0);
        power_down = 0;
        rd(4'he, 16'h3300);
        $display("test power down done");
        test_done();
    end
endmodule
